// >>> bench/dhbp_host.sv
// Host bus controller model: strobe cycles and the resolved data bus.
// Assumes the device samples its inputs on the rising edge of clock.
`timescale 1ns/100ps
`default_nettype none
module dhbp_host (
    input  wire logic       clock,
    input  wire logic [7:0] bus_out,
    input  wire logic [7:0] bus_oe,
    output logic            cs_n,
    output logic            wr_n,
    output logic            rd_n,
    output logic      [3:0] sel,
    output wire logic [7:0] bus
);
    logic [7:0] hd = 8'h00;
    logic       drv = 1'b0;
    logic [7:0] flt = 8'h69;
    // Drive enable seen at the data sample, clear of the clock edge
    logic [7:0] oe_seen = 8'h00;
    initial begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        sel = 4'h0;
    end
    // Released lines toggle so a stale value never passes for read data
    always @(posedge clock) flt <= ~flt;
    assign bus = (bus_oe & bus_out) | (~bus_oe & (drv ? hd : flt));
    // one strobe, select held, write ends on rise
    task automatic xfer(input logic c, input logic w, input logic [3:0] s,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        cs_n <= c;
        wr_n <= !w;
        rd_n <= w;
        sel <= s;
        hd <= d;
        drv <= w;
        repeat (2) @(posedge clock);
        #1 q = bus;
        oe_seen = bus_oe;
        @(posedge clock);
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        @(posedge clock);
        cs_n <= 1'b1;
        drv <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> bench/dhbp_port_checker.sv
// Checker for the host bus port: bus drive, reset effects, interrupt line.
// Assumes it is bound into dhbp_port and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module dhbp_port_checker (
    input wire logic       clock,
    input wire logic       rstn,
    input wire logic       device_reset,
    input wire logic       chip_select_n,
    input wire logic       write_strobe_n,
    input wire logic       read_strobe_n,
    input wire logic [7:0] host_data_bus_oe,
    input wire logic [7:0] general_output_pins,
    input wire logic [7:0] output_port_config_reg,
    input wire logic       timer_halt,
    input wire logic       serial_out_chan_a,
    input wire logic       serial_out_chan_b,
    input wire logic [7:0] chan_a_mode_zero,
    input wire logic [7:0] chan_b_mode_zero,
    input wire logic       irq_request_n_out,
    input wire logic       irq_request_n_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////
    chk_cs_float: assert property (
        chip_select_n |-> host_data_bus_oe == 8'h00)
        else $error("data bus driven while deselected");
    chk_oe_cause: assert property (
        host_data_bus_oe != 8'h00 |-> !chip_select_n && !read_strobe_n)
        else $error("data bus driven outside a read");
    chk_read_drive: assert property (
        (!device_reset && read_strobe_n && write_strobe_n) ##1
        (!device_reset && !chip_select_n && !read_strobe_n && write_strobe_n) [*2]
        |-> host_data_bus_oe == 8'hFF)
        else $error("read not answered on all lines");
    chk_reset_pins: assert property (
        device_reset |=> general_output_pins == 8'hFF && timer_halt
                         && output_port_config_reg == 8'h00)
        else $error("reset left pins, timer or config wrong");
    chk_reset_mark: assert property (
        device_reset |=> serial_out_chan_a && serial_out_chan_b)
        else $error("serial output not at mark in reset");
    chk_reset_mode: assert property (
        device_reset |=> chan_a_mode_zero == 8'h00 && chan_b_mode_zero == 8'h00)
        else $error("mode word zero not cleared by reset");
    chk_irq_drain: assert property (
        irq_request_n_oe |-> irq_request_n_out == 1'b0)
        else $error("interrupt line not pulled low");
    chk_irq_reset: assert property (
        device_reset |=> !irq_request_n_oe)
        else $error("interrupt asserted through reset");
    chk_pins_cause: assert property (
        $changed(general_output_pins) |-> !$past(chip_select_n, 2) || !$past(chip_select_n, 3)
        || !$past(chip_select_n, 4) || $past(device_reset) || $past(device_reset, 2)
        || $past(!rstn) || $past(!rstn, 2))
        else $error("output pins changed without a write");
    cov_read: cover property (host_data_bus_oe == 8'hFF);
    cov_reset: cover property (device_reset ##1 !device_reset);
    cov_irq: cover property ($rose(irq_request_n_oe));
endmodule
bind dhbp_port dhbp_port_checker u_chk (
    .clock(clock), .rstn(rstn), .device_reset(device_reset),
    .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .host_data_bus_oe(host_data_bus_oe),
    .general_output_pins(general_output_pins), .timer_halt(timer_halt),
    .output_port_config_reg(output_port_config_reg),
    .serial_out_chan_a(serial_out_chan_a), .serial_out_chan_b(serial_out_chan_b),
    .chan_a_mode_zero(chan_a_mode_zero), .chan_b_mode_zero(chan_b_mode_zero),
    .irq_request_n_out(irq_request_n_out), .irq_request_n_oe(irq_request_n_oe));
`default_nettype wire

// >>> bench/tb_duart_host_bus_port.sv
// Testbench for the host bus port: register, reset and interrupt scenarios.
// Assumes dhbp_host drives the strobes and resolves the shared data bus.
`timescale 1ns/100ps
`default_nettype none
module tb_duart_host_bus_port;
    logic       clock = 1'b0;
    logic       rstn = 1'b0;
    logic       dev_rst = 1'b0;
    logic [7:0] a_ev = 8'h00;
    logic [7:0] b_ev = 8'h00;
    logic [7:0] i_ev = 8'h00;
    logic       a_tx = 1'b0;
    logic       b_tx = 1'b0;
    logic [7:0] q;
    int         error_cnt = 0;
    int         n_compared = 0;
    wire        cs_n, wr_n, rd_n, tx_a, tx_b, halt, irq_out, irq_oe;
    wire  [3:0] sel;
    wire  [7:0] bus, d_out, d_oe, pins, opcfg, a_m0, a_m1, a_m2, b_m0, b_m1, b_m2;
    // Pull-up on the interrupt line
    wire        irq_line = irq_oe ? irq_out : 1'b1;
    always #2 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////
    dhbp_port dut (.clock(clock), .rstn(rstn), .device_reset(dev_rst),
        .chip_select_n(cs_n), .write_strobe_n(wr_n), .read_strobe_n(rd_n),
        .register_select(sel), .host_data_bus_in(bus), .host_data_bus_out(d_out),
        .host_data_bus_oe(d_oe), .chan_a_events(a_ev), .chan_b_events(b_ev),
        .irq_events(i_ev), .chan_a_tx_bit(a_tx), .chan_b_tx_bit(b_tx),
        .serial_out_chan_a(tx_a), .serial_out_chan_b(tx_b), .general_output_pins(pins),
        .output_port_config_reg(opcfg), .timer_halt(halt), .chan_a_mode_zero(a_m0),
        .chan_a_mode_one(a_m1), .chan_a_mode_two(a_m2), .chan_b_mode_zero(b_m0),
        .chan_b_mode_one(b_m1), .chan_b_mode_two(b_m2), .irq_request_n_out(irq_out),
        .irq_request_n_oe(irq_oe));
    dhbp_host host (.clock(clock), .bus_out(d_out), .bus_oe(d_oe), .cs_n(cs_n),
        .wr_n(wr_n), .rd_n(rd_n), .sel(sel), .bus(bus));
    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] s, input logic [7:0] d);
        host.xfer(1'b0, 1'b1, s, d, q);
    endtask
    task automatic rd_chk(input logic [3:0] s, input logic [7:0] e);
        host.xfer(1'b0, 1'b0, s, 8'h00, q);
        chk8(q, e);
    endtask
    task automatic settle;
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic pulse_reset;
        @(posedge clock);
        dev_rst <= 1'b1;
        @(posedge clock);
        dev_rst <= 1'b0;
        settle;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic s_reset;
        settle;
        chk8(pins, 8'hFF);
        chk8(d_oe, 8'h00);
        chk8({tx_a, tx_b, halt, irq_line, 4'h0}, 8'hD0);
        rd_chk(dhbp_pkg::SEL_IMASK, 8'h00);
    endtask
    task automatic s_deselect;
        host.xfer(1'b1, 1'b1, dhbp_pkg::SEL_IMASK, 8'h3C, q);
        host.xfer(1'b1, 1'b0, dhbp_pkg::SEL_IMASK, 8'h00, q);
        chk8(host.oe_seen, 8'h00);
        rd_chk(dhbp_pkg::SEL_IMASK, 8'h00);
    endtask
    task automatic s_regs;
        wr(dhbp_pkg::SEL_IMASK, 8'hC4);
        rd_chk(dhbp_pkg::SEL_IMASK, 8'hC4);
        wr(dhbp_pkg::SEL_OPVAL, 8'h01);
        settle;
        chk8(pins, 8'hFE);
        rd_chk(dhbp_pkg::SEL_OPVAL, 8'h01);
        wr(dhbp_pkg::SEL_OPCFG, 8'h81);
        settle;
        chk8(opcfg, 8'h81);
        rd_chk(4'hF, 8'h00);
    endtask
    task automatic s_mode;
        wr(4'h0, 8'h11);
        wr(4'h0, 8'h22);
        wr(4'h2, dhbp_pkg::CMD_PTR_MR0);
        wr(4'h0, 8'h33);
        wr(4'h8, 8'h44);
        wr(4'h8, 8'h66);
        settle;
        chk8(b_m2, 8'h66);
        chk8(a_m1, 8'h11);
        chk8(a_m2, 8'h22);
        chk8(a_m0, 8'h33);
        chk8(b_m1, 8'h44);
        pulse_reset;
        chk8(a_m0, 8'h00);
        chk8(opcfg, 8'h00);
        chk8(pins, 8'hFF);
        rd_chk(dhbp_pkg::SEL_IMASK, 8'h00);
        rd_chk(dhbp_pkg::SEL_OPVAL, 8'h00);
        wr(4'h0, 8'h55);
        settle;
        chk8(a_m1, 8'h55);
    endtask
    task automatic s_tx;
        wr(4'h2, 8'h01 << dhbp_pkg::CMD_TX_EN);
        settle;
        chk8({7'h00, tx_a}, 8'h00);
        pulse_reset;
        chk8({7'h00, tx_a}, 8'h01);
    endtask
    task automatic s_irq;
        @(posedge clock);
        i_ev <= 8'h10;
        @(posedge clock);
        i_ev <= 8'h00;
        settle;
        chk8({7'h00, irq_line}, 8'h01);
        rd_chk(dhbp_pkg::SEL_ISTAT, 8'h10);
        wr(dhbp_pkg::SEL_IMASK, 8'h10);
        settle;
        chk8({7'h00, irq_line}, 8'h00);
        wr(dhbp_pkg::SEL_ISTAT, 8'h10);
        settle;
        chk8({7'h00, irq_line}, 8'h01);
    endtask
    task automatic s_chan;
        @(posedge clock);
        a_ev <= 8'h02;
        @(posedge clock);
        a_ev <= 8'h00;
        rd_chk(4'h1, 8'h02);
        rd_chk(4'h9, 8'h00);
        pulse_reset;
        rd_chk(4'h1, 8'h00);
    endtask
    initial begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        s_reset;
        s_deselect;
        s_regs;
        s_mode;
        s_tx;
        s_irq;
        s_chan;
        wrap_up;
    end
    initial begin
        #100000;
        error_cnt++;
        wrap_up;
    end
endmodule
`default_nettype wire

// >>> hw/dhbp_chan.sv
// One serial channel's host-visible state: mode words, pointer, status, enable.
// Assumes one-cycle write and read pulses from the bus port sequencer.
`timescale 1ns/100ps
`default_nettype none

module dhbp_chan (
    input  wire logic                          clock,
    input  wire logic                          rstn,
    input  wire logic                          device_reset,
    input  wire logic                          wr_pulse,
    input  wire logic                          rd_pulse,
    input  wire logic [dhbp_pkg::LOCAL_W-1:0]  sel_local,
    input  wire logic [dhbp_pkg::DATA_W-1:0]   wdata,
    input  wire logic [dhbp_pkg::DATA_W-1:0]   status_events,
    output logic      [dhbp_pkg::DATA_W-1:0]   mode_rdata,
    output logic      [dhbp_pkg::DATA_W-1:0]   status_r,
    output logic                               active_r,
    output logic      [dhbp_pkg::DATA_W-1:0]   mode_word_zero,
    output logic      [dhbp_pkg::DATA_W-1:0]   mode_word_one,
    output logic      [dhbp_pkg::DATA_W-1:0]   mode_word_two
);

    logic                 clr;
    logic                 mode_acc;
    logic                 mode_wr;
    logic                 cmd_wr;
    logic                 stat_wr;
    dhbp_pkg::dhbp_mptr_t mptr_r;

    assign clr      = !rstn || device_reset;
    assign mode_acc = (wr_pulse || rd_pulse) && sel_local == dhbp_pkg::LOC_MODE;
    assign mode_wr  = wr_pulse && sel_local == dhbp_pkg::LOC_MODE;
    assign cmd_wr   = wr_pulse && sel_local == dhbp_pkg::LOC_CMD;
    assign stat_wr  = wr_pulse && sel_local == dhbp_pkg::LOC_STATUS;

    always_comb begin
        case (mptr_r)
            dhbp_pkg::MPTR_MR0: mode_rdata = mode_word_zero;
            dhbp_pkg::MPTR_MR1: mode_rdata = mode_word_one;
            default:            mode_rdata = mode_word_two;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // pointer reset
    // Pointer walks MR0, MR1, MR2 and parks on MR2 until a command moves it
    always_ff @(posedge clock) begin
        if (clr) begin
            mptr_r <= dhbp_pkg::MPTR_MR1;
        end else if (cmd_wr && wdata == dhbp_pkg::CMD_PTR_MR1) begin
            mptr_r <= dhbp_pkg::MPTR_MR1;
        end else if (cmd_wr && wdata == dhbp_pkg::CMD_PTR_MR0) begin
            mptr_r <= dhbp_pkg::MPTR_MR0;
        end else if (mode_acc) begin
            case (mptr_r)
                dhbp_pkg::MPTR_MR0: mptr_r <= dhbp_pkg::MPTR_MR1;
                default:            mptr_r <= dhbp_pkg::MPTR_MR2;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (clr) begin
            mode_word_zero <= dhbp_pkg::ZERO_BYTE;
        end else if (mode_wr && mptr_r == dhbp_pkg::MPTR_MR0) begin
            mode_word_zero <= wdata;
        end
    end

    // Only the zeroth word clears on device_reset; the others keep host values and clear on rstn only
    always_ff @(posedge clock) begin
        if (!rstn) begin
            mode_word_one <= dhbp_pkg::ZERO_BYTE;
            mode_word_two <= dhbp_pkg::ZERO_BYTE;
        end else if (mode_wr && mptr_r == dhbp_pkg::MPTR_MR1) begin
            mode_word_one <= wdata;
        end else if (mode_wr && mptr_r == dhbp_pkg::MPTR_MR2) begin
            mode_word_two <= wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status cleared
    // Write-one-to-clear; a fresh event in the same cycle survives the clear
    always_ff @(posedge clock) begin
        if (clr) begin
            status_r <= dhbp_pkg::ZERO_BYTE;
        end else begin
            status_r <= (status_r & ~(stat_wr ? wdata : dhbp_pkg::ZERO_BYTE)) | status_events;
        end
    end

    always_ff @(posedge clock) begin
        if (clr) begin
            active_r <= 1'b0;
        end else if (cmd_wr && wdata[dhbp_pkg::CMD_TX_DIS]) begin
            active_r <= 1'b0;
        end else if (cmd_wr && wdata[dhbp_pkg::CMD_TX_EN]) begin
            active_r <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// >>> hw/dhbp_pkg.sv
// Constants for the host bus port of the dual serial controller.
// Assumes a single 250 MHz clock and host strobes already synchronous to it.
package dhbp_pkg;

    localparam int unsigned DATA_W  = 8;
    localparam int unsigned SEL_W   = 4;
    localparam int unsigned LOCAL_W = 3;

    // Register select map; bit 3 picks channel B for per-channel slots
    localparam logic [2:0] LOC_MODE   = 3'h0;
    localparam logic [2:0] LOC_STATUS = 3'h1;
    localparam logic [2:0] LOC_CMD    = 3'h2;
    localparam logic [3:0] SEL_OPCFG  = 4'h4;
    localparam logic [3:0] SEL_ISTAT  = 4'h5;
    localparam logic [3:0] SEL_IMASK  = 4'h6;
    localparam logic [3:0] SEL_OPVAL  = 4'h7;
    localparam int unsigned CHAN_BIT  = 3;

    // Channel command codes
    localparam logic [7:0] CMD_PTR_MR1 = 8'h10;
    localparam logic [7:0] CMD_PTR_MR0 = 8'hB0;
    localparam int unsigned CMD_TX_EN  = 2;
    localparam int unsigned CMD_TX_DIS = 3;

    // Reset values
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ALL_ONES  = 8'hFF;
    localparam logic       MARK      = 1'h1;

    // Mode word access pointer
    typedef enum logic [1:0] {
        MPTR_MR0 = 2'h0,
        MPTR_MR1 = 2'h1,
        MPTR_MR2 = 2'h3
    } dhbp_mptr_t;

    // Strobe sequencer, Gray along idle->write and idle->read
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_WRITE = 2'h1,
        ST_READ  = 2'h2
    } dhbp_state_t;

endpackage

// >>> hw/dhbp_port.sv
// Host parallel bus port of a dual serial controller: strobe sequencing,
// register select decode, shared registers, reset effects, interrupt request.
// Assumes host strobes and data are synchronous to clock (250 MHz) and each
// strobe low phase lasts at least two clock cycles.
`timescale 1ns/100ps
`default_nettype none

module dhbp_port (
    input  wire logic                          clock,
    input  wire logic                          rstn,
    input  wire logic                          device_reset,
    input  wire logic                          chip_select_n,
    input  wire logic                          write_strobe_n,
    input  wire logic                          read_strobe_n,
    input  wire logic [dhbp_pkg::SEL_W-1:0]    register_select,
    input  wire logic [dhbp_pkg::DATA_W-1:0]   host_data_bus_in,
    output logic      [dhbp_pkg::DATA_W-1:0]   host_data_bus_out,
    output logic      [dhbp_pkg::DATA_W-1:0]   host_data_bus_oe,
    input  wire logic [dhbp_pkg::DATA_W-1:0]   chan_a_events,
    input  wire logic [dhbp_pkg::DATA_W-1:0]   chan_b_events,
    input  wire logic [dhbp_pkg::DATA_W-1:0]   irq_events,
    input  wire logic                          chan_a_tx_bit,
    input  wire logic                          chan_b_tx_bit,
    output logic                               serial_out_chan_a,
    output logic                               serial_out_chan_b,
    output logic      [dhbp_pkg::DATA_W-1:0]   general_output_pins,
    output logic      [dhbp_pkg::DATA_W-1:0]   output_port_config_reg,
    output logic                               timer_halt,
    output logic      [dhbp_pkg::DATA_W-1:0]   chan_a_mode_zero,
    output logic      [dhbp_pkg::DATA_W-1:0]   chan_a_mode_one,
    output logic      [dhbp_pkg::DATA_W-1:0]   chan_a_mode_two,
    output logic      [dhbp_pkg::DATA_W-1:0]   chan_b_mode_zero,
    output logic      [dhbp_pkg::DATA_W-1:0]   chan_b_mode_one,
    output logic      [dhbp_pkg::DATA_W-1:0]   chan_b_mode_two,
    output logic                               irq_request_n_out,
    output logic                               irq_request_n_oe
);

    localparam logic [dhbp_pkg::DATA_W-1:0] LANES_OFF = dhbp_pkg::ZERO_BYTE;
    localparam logic [dhbp_pkg::DATA_W-1:0] LANES_ON  = dhbp_pkg::ALL_ONES;

    ////////////////////////////////////////////////////////////////////////////
    // Select decode helpers

    function automatic logic is_chan(input logic [dhbp_pkg::SEL_W-1:0] sel,
                                     input logic                       chan_b);
        is_chan = sel[dhbp_pkg::CHAN_BIT] == chan_b
                  && sel[dhbp_pkg::LOCAL_W-1:0] <= dhbp_pkg::LOC_CMD;
    endfunction

    function automatic logic [dhbp_pkg::LOCAL_W-1:0] local_of(
        input logic [dhbp_pkg::SEL_W-1:0] sel);
        local_of = sel[dhbp_pkg::LOCAL_W-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Strobe sequencer

    dhbp_pkg::dhbp_state_t          state_r;
    logic [dhbp_pkg::DATA_W-1:0]    wr_data_r;
    logic [dhbp_pkg::SEL_W-1:0]     wr_sel_r;
    logic                           wr_pulse;
    logic                           rd_pulse;
    logic                           clr;
    logic                           a_wr;
    logic                           b_wr;
    logic                           a_rd;
    logic                           b_rd;

    assign clr = !rstn || device_reset;

    // read starts on the falling strobe
    assign rd_pulse = state_r == dhbp_pkg::ST_IDLE && !chip_select_n
                      && !read_strobe_n && write_strobe_n;
    assign wr_pulse = state_r == dhbp_pkg::ST_WRITE && write_strobe_n && !chip_select_n;

    // write wins if both strobes fall together
    always_ff @(posedge clock) begin
        if (clr) begin
            state_r <= dhbp_pkg::ST_IDLE;
        end else begin
            case (state_r)
                dhbp_pkg::ST_IDLE: begin
                    if (!chip_select_n && !write_strobe_n) begin
                        state_r <= dhbp_pkg::ST_WRITE;
                    end else if (rd_pulse) begin
                        state_r <= dhbp_pkg::ST_READ;
                    end
                end
                dhbp_pkg::ST_WRITE: begin
                    if (write_strobe_n || chip_select_n) begin
                        state_r <= dhbp_pkg::ST_IDLE;
                    end
                end
                dhbp_pkg::ST_READ: begin
                    if (read_strobe_n || chip_select_n) begin
                        state_r <= dhbp_pkg::ST_IDLE;
                    end
                end
                default: state_r <= dhbp_pkg::ST_IDLE;
            endcase
        end
    end

    // hold the last bus value seen while the strobe is low
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wr_data_r <= dhbp_pkg::ZERO_BYTE;
            wr_sel_r  <= '0;
        end else if (!chip_select_n && !write_strobe_n) begin
            wr_data_r <= host_data_bus_in;
            wr_sel_r  <= register_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channels

    logic [dhbp_pkg::DATA_W-1:0] a_mode_rdata;
    logic [dhbp_pkg::DATA_W-1:0] b_mode_rdata;
    logic [dhbp_pkg::DATA_W-1:0] chan_a_status_reg;
    logic [dhbp_pkg::DATA_W-1:0] chan_b_status_reg;
    logic                        a_active;
    logic                        b_active;

    assign a_wr = wr_pulse && is_chan(wr_sel_r, 1'b0);
    assign b_wr = wr_pulse && is_chan(wr_sel_r, 1'b1);
    assign a_rd = rd_pulse && is_chan(register_select, 1'b0);
    assign b_rd = rd_pulse && is_chan(register_select, 1'b1);

    dhbp_chan u_chan_a (
        .clock          (clock),
        .rstn           (rstn),
        .device_reset   (device_reset),
        .wr_pulse       (a_wr),
        .rd_pulse       (a_rd),
        .sel_local      (a_wr ? local_of(wr_sel_r) : local_of(register_select)),
        .wdata          (wr_data_r),
        .status_events  (chan_a_events),
        .mode_rdata     (a_mode_rdata),
        .status_r       (chan_a_status_reg),
        .active_r       (a_active),
        .mode_word_zero (chan_a_mode_zero),
        .mode_word_one  (chan_a_mode_one),
        .mode_word_two  (chan_a_mode_two)
    );

    dhbp_chan u_chan_b (
        .clock          (clock),
        .rstn           (rstn),
        .device_reset   (device_reset),
        .wr_pulse       (b_wr),
        .rd_pulse       (b_rd),
        .sel_local      (b_wr ? local_of(wr_sel_r) : local_of(register_select)),
        .wdata          (wr_data_r),
        .status_events  (chan_b_events),
        .mode_rdata     (b_mode_rdata),
        .status_r       (chan_b_status_reg),
        .active_r       (b_active),
        .mode_word_zero (chan_b_mode_zero),
        .mode_word_one  (chan_b_mode_one),
        .mode_word_two  (chan_b_mode_two)
    );

    // mark while inactive or in reset
    always_ff @(posedge clock) begin
        if (clr) begin
            serial_out_chan_a <= dhbp_pkg::MARK;
            serial_out_chan_b <= dhbp_pkg::MARK;
        end else begin
            serial_out_chan_a <= a_active ? chan_a_tx_bit : dhbp_pkg::MARK;
            serial_out_chan_b <= b_active ? chan_b_tx_bit : dhbp_pkg::MARK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared registers

    logic [dhbp_pkg::DATA_W-1:0] irq_mask_reg;
    logic [dhbp_pkg::DATA_W-1:0] irq_status_reg;
    logic [dhbp_pkg::DATA_W-1:0] output_port_value_reg;

    always_ff @(posedge clock) begin
        if (clr) begin
            irq_mask_reg           <= dhbp_pkg::ZERO_BYTE;
            output_port_value_reg  <= dhbp_pkg::ZERO_BYTE;
            output_port_config_reg <= dhbp_pkg::ZERO_BYTE;
        end else if (wr_pulse) begin
            case (wr_sel_r)
                dhbp_pkg::SEL_IMASK: irq_mask_reg           <= wr_data_r;
                dhbp_pkg::SEL_OPVAL: output_port_value_reg  <= wr_data_r;
                dhbp_pkg::SEL_OPCFG: output_port_config_reg <= wr_data_r;
                default: ;
            endcase
        end
    end

    // Write-one-to-clear; a new condition in the clearing cycle is kept
    always_ff @(posedge clock) begin
        if (clr) begin
            irq_status_reg <= dhbp_pkg::ZERO_BYTE;
        end else if (wr_pulse && wr_sel_r == dhbp_pkg::SEL_ISTAT) begin
            irq_status_reg <= (irq_status_reg & ~wr_data_r) | irq_events;
        end else begin
            irq_status_reg <= irq_status_reg | irq_events;
        end
    end

    // pins high, timer halted
    // Pins show the inverted value so a cleared register idles them high
    always_ff @(posedge clock) begin
        if (clr) begin
            general_output_pins <= dhbp_pkg::ALL_ONES;
            timer_halt          <= 1'b1;
        end else begin
            general_output_pins <= ~output_port_value_reg;
            timer_halt          <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (clr) begin
            irq_request_n_oe <= 1'b0;
        end else begin
            irq_request_n_oe <= |(irq_status_reg & irq_mask_reg);
        end
    end
    assign irq_request_n_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    logic [dhbp_pkg::DATA_W-1:0] rd_mux;
    logic                        drive_r;

    // bit zero is the LSB, no lane swap
    always_comb begin
        rd_mux = dhbp_pkg::ZERO_BYTE;
        if (is_chan(register_select, 1'b0) || is_chan(register_select, 1'b1)) begin
            case (local_of(register_select))
                dhbp_pkg::LOC_MODE:
                    rd_mux = register_select[dhbp_pkg::CHAN_BIT] ? b_mode_rdata : a_mode_rdata;
                dhbp_pkg::LOC_STATUS:
                    rd_mux = register_select[dhbp_pkg::CHAN_BIT] ? chan_b_status_reg
                                                                 : chan_a_status_reg;
                default: rd_mux = dhbp_pkg::ZERO_BYTE;
            endcase
        end else begin
            case (register_select)
                dhbp_pkg::SEL_ISTAT: rd_mux = irq_status_reg;
                dhbp_pkg::SEL_IMASK: rd_mux = irq_mask_reg;
                dhbp_pkg::SEL_OPVAL: rd_mux = output_port_value_reg;
                dhbp_pkg::SEL_OPCFG: rd_mux = output_port_config_reg;
                default:             rd_mux = dhbp_pkg::ZERO_BYTE;
            endcase
        end
    end

    // data sampled once at the strobe fall
    always_ff @(posedge clock) begin
        if (clr) begin
            host_data_bus_out <= dhbp_pkg::ZERO_BYTE;
        end else if (rd_pulse) begin
            host_data_bus_out <= rd_mux;
        end
    end

    always_ff @(posedge clock) begin
        if (clr) begin
            drive_r <= 1'b0;
        end else begin
            drive_r <= rd_pulse || (state_r == dhbp_pkg::ST_READ
                                    && !read_strobe_n && !chip_select_n);
        end
    end

    // chip select high releases the bus at once
    assign host_data_bus_oe = (drive_r && !chip_select_n && !read_strobe_n) ? LANES_ON
                                                                             : LANES_OFF;

endmodule

`default_nettype wire
